/* File: src/adc_config_register_bank.v */
`timescale 1ns/1ps
`include "adc_cfg_map.vh"

// How it works
// - Soft reset only when bits 7 and 0 are both set in one write.
// - Soft reset restores all registers to defaults except interface setup.
// - Streaming access lowers the address by one after every data byte.
// - Address direction bit 5 is read-only and always reads zero.
// - Writes leave read-only bits untouched, updating only writable bits.
// - Serial accesses are served only while configuration mode is active.
module adc_config_register_bank (
    input  wire        mclk_in,
    input  wire        sys_rst_in,
    input  wire        cfg_mode_in,
    input  wire        sclk_in,
    input  wire        cs_n_in,
    input  wire        sdi_in,
    output wire        sdo_out,
    output wire        sdo_oe_out,
    output wire [15:0] ch0_gain_out,
    output wire [15:0] ch1_gain_out,
    output wire [7:0]  modes_out,
    output wire [7:0]  osc_ctrl_out,
    output wire [7:0]  pin_drive_out,
    output wire [31:0] pattern_out,
    output wire [7:0]  diag_out,
    output wire [7:0]  err_out,
    output wire        soft_reset_out
);

    localparam ST_INSTR = 1'b0;
    localparam ST_DATA  = 1'b1;

    reg  [7:0]  bank_r [0:`LAST_IDX];
    reg         sclk_q_r;
    reg         state_r;
    reg  [3:0]  bit_cnt_r;
    reg  [15:0] shift_r;
    reg  [14:0] addr_r;
    reg         read_r;
    reg  [7:0]  tx_r;
    reg         sdo_r;
    reg         soft_rst_r;
    integer     i;

    // Sclk is sampled by mclk, never used as a clock, so each
    // sclk phase must last at least one mclk period
    wire        active   = cfg_mode_in & ~cs_n_in;
    wire        sclk_up  = active & sclk_in & ~sclk_q_r;
    wire        sclk_dn  = active & ~sclk_in & sclk_q_r;
    wire [15:0] sh_nxt   = {shift_r[14:0], sdi_in};
    // Wraps from zero to the top of the space, never ascends
    wire [14:0] addr_dec = addr_r - 15'h0001;

    function [3:0] slot;
        input [14:0] a;
        begin
            case (a)
                `OFS_IFA:    slot = `IDX_IFA;
                `OFS_CH0_GL: slot = `IDX_CH0_GL;
                `OFS_CH0_GH: slot = `IDX_CH0_GH;
                `OFS_CH1_GL: slot = `IDX_CH1_GL;
                `OFS_CH1_GH: slot = `IDX_CH1_GH;
                `OFS_MODES:  slot = `IDX_MODES;
                `OFS_OSC:    slot = `IDX_OSC;
                `OFS_PINDRV: slot = `IDX_PINDRV;
                `OFS_PAT0:   slot = `IDX_PAT0;
                `OFS_PAT1:   slot = `IDX_PAT1;
                `OFS_PAT2:   slot = `IDX_PAT2;
                `OFS_PAT3:   slot = `IDX_PAT3;
                `OFS_DIAG:   slot = `IDX_DIAG;
                `OFS_ERR:    slot = `IDX_ERR;
                default:     slot = `IDX_NONE;
            endcase
        end
    endfunction

    function [7:0] rst_val;
        input [3:0] s;
        begin
            case (s)
                `IDX_IFA:    rst_val = `RST_IFA;
                `IDX_CH0_GH: rst_val = `RST_GAIN_H;
                `IDX_CH1_GH: rst_val = `RST_GAIN_H;
                `IDX_PAT0:   rst_val = `RST_PAT01;
                `IDX_PAT1:   rst_val = `RST_PAT01;
                `IDX_PAT2:   rst_val = `RST_PAT23;
                `IDX_PAT3:   rst_val = `RST_PAT23;
                `IDX_DIAG:   rst_val = `RST_DIAG;
                default:     rst_val = `RST_ZERO;
            endcase
        end
    endfunction

    // Direction and output-enable bits sit outside the mask
    function [7:0] wmask;
        input [3:0] s;
        begin
            case (s)
                `IDX_IFA:    wmask = `WM_IFA;
                `IDX_PINDRV: wmask = `WM_PINDRV;
                `IDX_DIAG:   wmask = `WM_DIAG;
                `IDX_ERR:    wmask = `WM_ERR;
                `IDX_NONE:   wmask = `WM_NONE;
                default:     wmask = `WM_ALL;
            endcase
        end
    endfunction

    // Unmapped addresses read as zero so a stream may cross gaps
    function [7:0] rd_val;
        input [14:0] a;
        reg   [3:0]  s;
        begin
            s = slot(a);
            if (s == `IDX_NONE) begin
                rd_val = `RST_ZERO;
            end else begin
                rd_val = bank_r[s];
            end
        end
    endfunction

    // Write path: one byte lands at the eighth data rise
    wire [3:0] wr_slot = slot(addr_r);
    wire [7:0] wr_m    = wmask(wr_slot);
    wire       commit  = sclk_up & (state_r == ST_DATA) & ~read_r &
                         (bit_cnt_r == `BYTE_LAST);
    // Both reset bits must come in one byte; a bit left set by an
    // earlier write does not count
    wire       do_rst  = commit & (wr_slot == `IDX_IFA) &
                         sh_nxt[`BIT_RST_UPPER] &
                         sh_nxt[`BIT_RST_LOWER];

    // Register bank: hard reset, soft reset, or one masked byte write
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (i = 0; i < `NUM_REGS; i = i + 1) begin
                bank_r[i] <= rst_val(i[3:0]);
            end
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= do_rst;
            if (do_rst) begin
                // Interface setup keeps its old value
                for (i = 1; i < `NUM_REGS; i = i + 1) begin
                    bank_r[i] <= rst_val(i[3:0]);
                end
            end else if (commit && wr_slot != `IDX_NONE) begin
                bank_r[wr_slot] <= (bank_r[wr_slot] & ~wr_m) |
                                   (sh_nxt[7:0] & wr_m);
            end
        end
    end

    // Serial framing: 16-bit instruction, then bytes, MSB first
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_q_r  <= 1'b0;
            state_r   <= ST_INSTR;
            bit_cnt_r <= 4'h0;
            shift_r   <= 16'h0000;
            addr_r    <= 15'h0000;
            read_r    <= 1'b0;
            tx_r      <= 8'h00;
            sdo_r     <= 1'b0;
        end else begin
            sclk_q_r <= sclk_in;
            if (!active) begin
                // Frame end or mode exit abandons any partial byte
                state_r   <= ST_INSTR;
                bit_cnt_r <= 4'h0;
            end else if (sclk_up) begin
                shift_r   <= sh_nxt;
                bit_cnt_r <= bit_cnt_r + 4'h1;
                case (state_r)
                    ST_INSTR: begin
                        // First byte loads now so bit 7 is ready at the fall
                        if (bit_cnt_r == `INSTR_LAST) begin
                            state_r   <= ST_DATA;
                            bit_cnt_r <= 4'h0;
                            read_r    <= sh_nxt[`BIT_RW];
                            addr_r    <= sh_nxt[14:0];
                            tx_r      <= rd_val(sh_nxt[14:0]);
                        end
                    end
                    ST_DATA: begin
                        if (bit_cnt_r == `BYTE_LAST) begin
                            bit_cnt_r <= 4'h0;
                            addr_r    <= addr_dec;
                            tx_r      <= rd_val(addr_dec);
                        end
                    end
                    default: begin
                        state_r <= ST_INSTR;
                    end
                endcase
            end else if (sclk_dn && state_r == ST_DATA) begin
                // Present on the falling edge so the host samples on rise
                sdo_r <= tx_r[7];
                tx_r  <= {tx_r[6:0], 1'b0};
            end
        end
    end

    assign sdo_out        = sdo_r;
    // Driver only on during the data phase of a selected read
    assign sdo_oe_out     = active & (state_r == ST_DATA) & read_r &
                            bank_r[`IDX_IFA][`BIT_SDO_EN];

    assign ch0_gain_out   = {bank_r[`IDX_CH0_GH], bank_r[`IDX_CH0_GL]};
    assign ch1_gain_out   = {bank_r[`IDX_CH1_GH], bank_r[`IDX_CH1_GL]};
    assign modes_out      = bank_r[`IDX_MODES];
    assign osc_ctrl_out   = bank_r[`IDX_OSC];
    assign pin_drive_out  = bank_r[`IDX_PINDRV];
    assign pattern_out    = {bank_r[`IDX_PAT3], bank_r[`IDX_PAT2],
                             bank_r[`IDX_PAT1], bank_r[`IDX_PAT0]};
    assign diag_out       = bank_r[`IDX_DIAG];
    assign err_out        = bank_r[`IDX_ERR];
    assign soft_reset_out = soft_rst_r;

endmodule

/* File: src/adc_cfg_map.vh */
`ifndef ADC_CFG_MAP_VH
`define ADC_CFG_MAP_VH

// Register offsets on the serial bus
`define OFS_IFA        15'h0000
`define OFS_CH0_GL     15'h001C
`define OFS_CH0_GH     15'h001D
`define OFS_CH1_GL     15'h001E
`define OFS_CH1_GH     15'h001F
`define OFS_MODES      15'h0020
`define OFS_OSC        15'h0021
`define OFS_PINDRV     15'h0022
`define OFS_PAT0       15'h0023
`define OFS_PAT1       15'h0024
`define OFS_PAT2       15'h0025
`define OFS_PAT3       15'h0026
`define OFS_DIAG       15'h0034
`define OFS_ERR        15'h0035

// Storage slots
`define IDX_IFA        4'h0
`define IDX_CH0_GL     4'h1
`define IDX_CH0_GH     4'h2
`define IDX_CH1_GL     4'h3
`define IDX_CH1_GH     4'h4
`define IDX_MODES      4'h5
`define IDX_OSC        4'h6
`define IDX_PINDRV     4'h7
`define IDX_PAT0       4'h8
`define IDX_PAT1       4'h9
`define IDX_PAT2       4'hA
`define IDX_PAT3       4'hB
`define IDX_DIAG       4'hC
`define IDX_ERR        4'hD
`define IDX_NONE       4'hF
`define NUM_REGS       14
`define LAST_IDX       13

// Reset values
`define RST_IFA        8'h10
`define RST_GAIN_L     8'h00
`define RST_GAIN_H     8'h80
`define RST_ZERO       8'h00
`define RST_PAT01      8'h0F
`define RST_PAT23      8'h5A
`define RST_DIAG       8'h40

// Writable bit masks
`define WM_IFA         8'h81
`define WM_PINDRV      8'h01
`define WM_DIAG        8'h41
`define WM_ERR         8'h01
`define WM_ALL         8'hFF
`define WM_NONE        8'h00

// Interface setup fields
`define BIT_RST_UPPER  7
`define BIT_DIR_SEL    5
`define BIT_SDO_EN     4
`define BIT_RST_LOWER  0

// Serial framing
`define INSTR_LAST     4'hF
`define BYTE_LAST      4'h7
`define BIT_RW         15

`endif

/* File: sim/cfg_bank_props.sv */
`timescale 1ns/1ps
module cfg_bank_props (
    input logic        mclk_in,
    input logic        sys_rst_in,
    input logic        cfg_mode_in,
    input logic        cs_n_in,
    input logic        sdo_oe_out,
    input logic [15:0] ch0_gain_out,
    input logic [31:0] pattern_out,
    input logic [7:0]  pin_drive_out,
    input logic [7:0]  diag_out,
    input logic [7:0]  err_out,
    input logic        soft_reset_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    a_oe_needs_select: assert property (
        sdo_oe_out |-> cfg_mode_in && !cs_n_in) else $error("sdo driven idle");
    a_idle_holds: assert property (
        !cfg_mode_in |=> $stable({ch0_gain_out, pattern_out, diag_out}))
        else $error("register changed outside config mode");
    a_gain_cause: assert property (
        $changed(ch0_gain_out) |-> $past(cfg_mode_in && !cs_n_in))
        else $error("gain changed without a selected frame");
    a_pulse_single: assert property (
        soft_reset_out |=> !soft_reset_out) else $error("soft reset pulse long");
    a_soft_defaults: assert property (
        soft_reset_out |-> ch0_gain_out == 16'h8000 && err_out == 8'h00
        && pattern_out == 32'h5A5A0F0F && diag_out == 8'h40)
        else $error("soft reset left a register set");
    a_ro_bits_low: assert property (
        !(pin_drive_out & 8'hFE) && !(diag_out & 8'hBE) && !(err_out & 8'hFE))
        else $error("read-only bit set");
    cover property (soft_reset_out);
    cover property (sdo_oe_out);
    cover property ($changed(pattern_out));
endmodule
bind adc_config_register_bank cfg_bank_props u_props (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cfg_mode_in(cfg_mode_in),
    .cs_n_in(cs_n_in), .sdo_oe_out(sdo_oe_out), .ch0_gain_out(ch0_gain_out),
    .pattern_out(pattern_out), .pin_drive_out(pin_drive_out),
    .diag_out(diag_out), .err_out(err_out), .soft_reset_out(soft_reset_out));

/* File: sim/host_spi_model.sv */
`timescale 1ns/1ps
module host_spi_model (
    input  logic mclk_in,
    input  logic sdo_in,
    output logic sclk_out = 1'b0,
    output logic cs_n_out = 1'b1,
    output logic sdi_out = 1'b0
);
    // Low 3 mclk so sdo has settled after the fall, high 3 mclk
    task automatic bit_io(input logic b, output logic r);
        @(posedge mclk_in) #1;
        sclk_out = 1'b0;
        sdi_out = b;
        repeat (3) @(posedge mclk_in);
        r = sdo_in;
        #1 sclk_out = 1'b1;
        repeat (2) @(posedge mclk_in);
    endtask
    // Instruction MSB first, then n bytes; read bits replace d
    task automatic xfer(input logic rd, input logic [14:0] a, input int n,
                        inout logic [31:0] d);
        logic r;
        @(posedge mclk_in) #1 cs_n_out = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            bit_io((i == 15) ? rd : a[i], r);
        end
        for (int i = 8 * n - 1; i >= 0; i--) begin
            bit_io(d[i], r);
            d[i] = r;
        end
        @(posedge mclk_in) #1;
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = ~sdi_out;
        repeat (2) @(posedge mclk_in);
    endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        mclk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic        cfg_mode_in = 1'b1;
    logic        sclk, cs_n, sdi, sdo, oe, srst;
    logic [15:0] g0, g1;
    logic [7:0]  modes, osc, pin, diag, err, mem [64], msk [64], dflt [64];
    logic [31:0] pat;
    logic [31:0] lfsr = 32'hDD9E61E0;
    int          failures = 0;
    int          total_checks = 0;
    int          srst_cnt = 0, srst_exp = 0, oe_cnt = 0;
    // Offset, default, writable mask
    logic [7:0]  tbl [42] = '{8'h00, 8'h10, 8'h81, 8'h1C, 8'h00, 8'hFF,
        8'h1D, 8'h80, 8'hFF, 8'h1E, 8'h00, 8'hFF, 8'h1F, 8'h80, 8'hFF,
        8'h20, 8'h00, 8'hFF, 8'h21, 8'h00, 8'hFF, 8'h22, 8'h00, 8'h01,
        8'h23, 8'h0F, 8'hFF, 8'h24, 8'h0F, 8'hFF, 8'h25, 8'h5A, 8'hFF,
        8'h26, 8'h5A, 8'hFF, 8'h34, 8'h40, 8'h41, 8'h35, 8'h00, 8'h01};
    logic [7:0]  st [4] = '{8'h26, 8'h1F, 8'h22, 8'h35};
    logic [7:0]  rs [3] = '{8'hA0, 8'h01, 8'hFF};
    initial forever #10 mclk_in = ~mclk_in;
    host_spi_model host (.mclk_in(mclk_in), .sdo_in(sdo), .sclk_out(sclk),
        .cs_n_out(cs_n), .sdi_out(sdi));
    adc_config_register_bank dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
        .cfg_mode_in(cfg_mode_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(oe), .ch0_gain_out(g0),
        .ch1_gain_out(g1), .modes_out(modes), .osc_ctrl_out(osc),
        .pin_drive_out(pin), .pattern_out(pat), .diag_out(diag),
        .err_out(err), .soft_reset_out(srst));
    always @(posedge mclk_in) if (srst === 1'b1) srst_cnt++;
    always @(posedge mclk_in) if (oe === 1'b1) oe_cnt++;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
        return lfsr;
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic model_wr(input int a, input logic [7:0] d);
        if (a == 0 && d[7] && d[0]) begin
            srst_exp++;
            for (int i = 1; i < 64; i++) mem[i] = dflt[i];
        end else begin
            mem[a] = (mem[a] & ~msk[a]) | (d & msk[a]);
        end
    endtask
    task automatic op(input logic rd, input int a, input int n,
                      input logic [31:0] d);
        logic [31:0] q;
        int          o0;
        q = d;
        o0 = oe_cnt;
        host.xfer(rd, a[14:0], n, q);
        for (int k = 0; k < n; k++) begin
            if (!rd && cfg_mode_in) model_wr(a - k, d[8*(n-k)-1 -: 8]);
            if (rd) check("rdata", q[8*(n-k)-1 -: 8], mem[a - k]);
        end
        @(posedge mclk_in) #1;
        check("gain0", g0, {mem[29], mem[28]});
        check("gain1", g1, {mem[31], mem[30]});
        check("misc", {modes, osc, pin, diag}, {mem[32], mem[33], mem[34],
            mem[52]});
        check("pat", pat, {mem[38], mem[37], mem[36], mem[35]});
        check("err", err, mem[53]);
        check("srst", srst_cnt, srst_exp);
        check("sdo_oe", oe_cnt > o0, rd);
    endtask
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        for (int i = 0; i < 64; i++) begin
            msk[i] = 8'h00;
            dflt[i] = 8'h00;
        end
        for (int j = 0; j < 14; j++) begin
            dflt[tbl[3*j]] = tbl[3*j+1];
            msk[tbl[3*j]] = tbl[3*j+2];
        end
        mem = dflt;
        repeat (12) @(posedge mclk_in);
        #1 sys_rst_in = 1'b0;
        for (int j = 0; j < 14; j++) op(1'b1, tbl[3*j], 1, 0);
        repeat (2) foreach (st[j]) begin
            op(1'b0, st[j], 4, rnd());
            op(1'b1, st[j], 4, 0);
        end
        cfg_mode_in = 1'b0;
        op(1'b0, 8'h1F, 4, rnd());
        cfg_mode_in = 1'b1;
        op(1'b1, 8'h1F, 4, 0);
        foreach (rs[j]) begin
            op(1'b0, 0, 1, rs[j]);
            op(1'b1, 0, 1, 0);
        end
        op(1'b1, 8'h26, 4, 0);
        report_and_stop();
    end
endmodule
